//--- sra_host.sv
// Behavioural serial master, mode 0, 160 ns clock.
// Assumes tasks are called from the bench at core clock falling edges.
`timescale 1ns/1ns
`default_nettype none
module sra_host (
  input  wire logic core_clk_i,
  input  wire logic miso_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b1;
  end
  task automatic half();
    repeat (10) @(negedge core_clk_i);
  endtask
  task automatic frame_on();
    half();
    cs_n_o = 1'b0;
    half();
  endtask
  // Clock stands still; data-in toggles so a held bit is never relied on
  task automatic frame_off();
    half();
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    half();
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = tx[i];
      half();
      sclk_o = 1'b1;
      rx[i] = miso_i;
      half();
      sclk_o = 1'b0;
    end
  endtask
endmodule // sra_host
`default_nettype wire

//--- sra_pkg.sv
// Constants for the serial register access slave.
// Assumes one core clock domain; serial pins are sampled asynchronously.
package sra_pkg;
  localparam logic [7:0] CMD_READ       = 8'h0B;
  localparam logic [7:0] CMD_WRITE      = 8'h02;
  localparam logic [1:0] DIR_DEC        = 2'b10;
  localparam logic [1:0] DIR_STATIC     = 2'b11;
  localparam int         ADDR_W         = 14;
  localparam int         DIR_MSB        = 7;
  localparam int         DIR_LSB        = 6;
  localparam int         DATA_W         = 32;
  localparam int         SIZE_W         = 2;
  localparam int         WORD_W         = ADDR_W + SIZE_W + DATA_W;
  localparam int         FIFO_DEPTH     = 32;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [2:0] TX_LOAD        = 3'h7;
  localparam int         RD_LAT         = 2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_RDATA,
    ST_WDATA,
    ST_WAKE,
    ST_SKIP
  } sra_state_e;
endpackage

//--- sra_slave.sv
// Serial register access slave with a write commit FIFO.
// Assumes the serial pins are asynchronous to core_clk_i and the serial clock is well below core rate.
`timescale 1ns/1ns
`default_nettype none

module sra_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0]   cnt_ff;
  logic          out_valid_ff;
  logic [W-1:0]  out_data_ff;
  logic          push;
  logic          pop;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = (cnt_ff != '0) && (!out_valid_ff || out_ready_i);
  assign in_ready_o  = ((cnt_ff + (AW+1)'(out_valid_ff)) != (AW+1)'(DEPTH));
  assign out_valid_o = out_valid_ff;
  assign out_data_o  = out_data_ff;
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
    if (pop) out_data_ff <= mem_ff[rd_ptr_ff];
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wr_ptr_ff    <= '0;
      rd_ptr_ff    <= '0;
      cnt_ff       <= '0;
      out_valid_ff <= 1'b0;
    end else begin
      out_valid_ff <= pop || (out_valid_ff && !out_ready_i);
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule // sra_fifo

module sra_slave (
  input  wire logic                           core_clk_i,
  input  wire logic                           nrst_i,
  input  wire logic                           init_done_i,
  input  wire logic                           wake_busy_i,
  input  wire logic                           sleep_allow_i,
  input  wire logic                           sclk_i,
  input  wire logic                           cs_n_i,
  input  wire logic                           serial_data_in_i,
  output logic                                sdo_o,
  output logic                                sdo_oe_n_o,
  output logic                                rd_req_o,
  output logic [sra_pkg::ADDR_W-1:0]          rd_addr_o,
  input  wire logic [7:0]                     rd_data_i,
  output logic [sra_pkg::ADDR_W-1:0]          cur_addr_o,
  input  wire logic [sra_pkg::SIZE_W-1:0]     reg_bytes_i,
  output logic                                wr_valid_o,
  input  wire logic                           wr_ready_i,
  output logic [sra_pkg::ADDR_W-1:0]          wr_addr_o,
  output logic [sra_pkg::SIZE_W-1:0]          wr_size_o,
  output logic [sra_pkg::DATA_W-1:0]          wr_data_o,
  output logic                                wr_overrun_o,
  output logic                                stay_awake_o
);
  import sra_pkg::*;

  logic [2:0]         sclk_sync_ff;
  logic [2:0]         cs_sync_ff;
  logic [1:0]         sdi_sync_ff;
  logic               armed_ff;
  sra_state_e         state_ff;
  logic [2:0]         bit_cnt_ff;
  logic [6:0]         shift_ff;
  logic               addr_lo_ff;
  logic               is_read_ff;
  logic [7:0]         addr_hi_ff;
  logic [1:0]         dir_ff;
  logic [ADDR_W-1:0]  addr_ff;
  logic               rd_req_ff;
  logic [ADDR_W-1:0]  rd_addr_ff;
  logic [RD_LAT-1:0]  rd_pend_ff;
  logic [7:0]         rd_buf_ff;
  logic [7:0]         tx_ff;
  logic [2:0]         tx_cnt_ff;
  logic               sdo_ff;
  logic               oe_n_ff;
  logic [SIZE_W-1:0]  wr_cnt_ff;
  logic [SIZE_W-1:0]  wr_size_ff;
  logic [ADDR_W-1:0]  wr_start_ff;
  logic [DATA_W-1:0]  wr_buf_ff;
  logic [WORD_W-1:0]  commit_ff;
  logic               commit_pend_ff;
  logic               overrun_ff;
  logic               awake_ff;
  logic               fifo_ready;
  logic [WORD_W-1:0]  fifo_out;
  logic               fifo_valid;

  logic               cs_hi;
  logic               cs_rise;
  logic               cs_fall;
  logic               rise;
  logic               fall;
  logic               live;
  logic               byte_done;
  logic [7:0]         byte_in;
  logic               ld_next;
  logic               wr_byte;
  logic [SIZE_W-1:0]  cur_size;
  logic               wr_last;
  logic [DATA_W-1:0]  nxt_wr_buf;

  function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a, input logic [1:0] d);
    unique case (d)
      DIR_DEC:    step_addr = a - 1'b1;
      DIR_STATIC: step_addr = a;
      default:    step_addr = a + 1'b1; // 00b and reserved 01b both increment
    endcase
  endfunction

  // Only the second stage is read; the third is its delayed copy for edges
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      sclk_sync_ff <= '0;
      cs_sync_ff   <= 3'h7;
      sdi_sync_ff  <= '0;
    end else begin
      sclk_sync_ff <= {sclk_sync_ff[1:0], sclk_i};
      cs_sync_ff   <= {cs_sync_ff[1:0], cs_n_i};
      sdi_sync_ff  <= {sdi_sync_ff[0], serial_data_in_i};
    end
  end

  assign cs_hi     = cs_sync_ff[1];
  assign cs_rise   = cs_sync_ff[1] && !cs_sync_ff[2];
  assign cs_fall   = !cs_sync_ff[1] && cs_sync_ff[2];
  assign rise      = sclk_sync_ff[1] && !sclk_sync_ff[2];
  assign fall      = !sclk_sync_ff[1] && sclk_sync_ff[2];
  assign live      = armed_ff && !cs_hi;
  assign byte_done = live && rise && (bit_cnt_ff == BIT_LAST);
  assign byte_in   = {shift_ff, sdi_sync_ff[1]}; // Msb first
  assign ld_next   = live && fall && (state_ff == ST_RDATA) && (tx_cnt_ff == '0);
  assign wr_byte   = byte_done && (state_ff == ST_WDATA);
  assign cur_size  = (wr_cnt_ff == '0) ? reg_bytes_i : wr_size_ff;
  assign wr_last   = (wr_cnt_ff == cur_size);

  always_comb begin
    nxt_wr_buf = wr_buf_ff;
    nxt_wr_buf[8*wr_cnt_ff +: 8] = byte_in;
  end

  // Arming needs a select rising edge after init, so a frame in progress is skipped
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || !init_done_i) begin
      armed_ff <= 1'b0;
    end else if (cs_rise) begin
      armed_ff <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || !armed_ff || cs_hi) begin
      state_ff   <= ST_IDLE;
      bit_cnt_ff <= '0;
      addr_lo_ff <= 1'b0;
    end else if (wake_busy_i || state_ff == ST_WAKE) begin
      state_ff <= ST_WAKE; // Held until select high
    end else begin
      if (rise) begin
        shift_ff   <= byte_in[6:0];
        bit_cnt_ff <= bit_cnt_ff + 1'b1;
      end
      unique case (state_ff)
        ST_IDLE: state_ff <= ST_CMD;
        ST_CMD: begin
          if (byte_done) begin
            is_read_ff <= (byte_in == CMD_READ);
            state_ff   <= (byte_in == CMD_READ || byte_in == CMD_WRITE) ? ST_ADDR : ST_SKIP;
          end
        end
        ST_ADDR: begin
          if (byte_done) begin
            addr_lo_ff <= 1'b1;
            if (!addr_lo_ff) begin
              addr_hi_ff <= byte_in; // High byte first
            end else begin
              dir_ff   <= addr_hi_ff[DIR_MSB:DIR_LSB];
              addr_ff  <= ADDR_W'({addr_hi_ff, byte_in});
              state_ff <= is_read_ff ? ST_DUMMY : ST_WDATA; // No dummy on writes
            end
          end
        end
        ST_DUMMY: if (byte_done) state_ff <= ST_RDATA; // Dummy content ignored
        ST_WDATA: if (byte_done) addr_ff <= step_addr(addr_ff, dir_ff);
        ST_RDATA: if (ld_next) addr_ff <= step_addr(addr_ff, dir_ff);
        ST_SKIP, ST_WAKE: state_ff <= state_ff;
      endcase
    end
  end

  // Read fetch: requested at the end of the dummy byte and at each byte load
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rd_req_ff  <= 1'b0;
      rd_addr_ff <= '0;
      rd_pend_ff <= '0;
      rd_buf_ff  <= '0;
    end else begin
      rd_req_ff  <= 1'b0;
      rd_pend_ff <= {rd_pend_ff[RD_LAT-2:0], 1'b0};
      if (byte_done && state_ff == ST_DUMMY && !wake_busy_i) begin
        rd_req_ff     <= 1'b1;
        rd_addr_ff    <= addr_ff;
        rd_pend_ff[0] <= 1'b1;
      end else if (ld_next && !wake_busy_i) begin
        rd_req_ff     <= 1'b1; // Next byte prefetched while this one shifts
        rd_addr_ff    <= step_addr(addr_ff, dir_ff);
        rd_pend_ff[0] <= 1'b1;
      end
      if (rd_pend_ff[RD_LAT-1]) begin
        rd_buf_ff <= rd_data_i;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || !live) begin
      sdo_ff    <= 1'b0;
      oe_n_ff   <= 1'b1; // Released while select high
      tx_ff     <= '0;
      tx_cnt_ff <= '0;
    end else if (state_ff == ST_WAKE || wake_busy_i) begin
      sdo_ff  <= 1'b0;
      oe_n_ff <= 1'b0;
    end else if (ld_next) begin
      sdo_ff    <= rd_buf_ff[7];
      oe_n_ff   <= 1'b0;
      tx_ff     <= {rd_buf_ff[6:0], 1'b0};
      tx_cnt_ff <= TX_LOAD;
    end else if (fall && state_ff == ST_RDATA) begin
      sdo_ff    <= tx_ff[7];
      tx_ff     <= {tx_ff[6:0], 1'b0};
      tx_cnt_ff <= tx_cnt_ff - 1'b1;
    end
  end

  // Bytes collect until the register width is reached; a short frame leaves nothing behind
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || !live) begin
      wr_cnt_ff <= '0; // Partial write discarded
    end else if (wr_byte && !wake_busy_i) begin
      if (wr_cnt_ff == '0) begin
        wr_size_ff  <= reg_bytes_i;
        wr_start_ff <= addr_ff;
      end
      wr_buf_ff <= nxt_wr_buf;
      wr_cnt_ff <= wr_last ? '0 : wr_cnt_ff + 1'b1;
    end
  end

  // A commit that finds the previous one still waiting overwrites it and flags overrun
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      commit_ff      <= '0;
      commit_pend_ff <= 1'b0;
      overrun_ff     <= 1'b0;
    end else begin
      if (commit_pend_ff && fifo_ready) begin
        commit_pend_ff <= 1'b0;
      end
      if (live && wr_byte && !wake_busy_i && wr_last) begin
        commit_ff      <= {(wr_cnt_ff == '0) ? addr_ff : wr_start_ff, cur_size, nxt_wr_buf};
        commit_pend_ff <= 1'b1;
        if (commit_pend_ff && !fifo_ready) begin
          overrun_ff <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      awake_ff <= 1'b0;
    end else if (armed_ff && cs_fall) begin
      awake_ff <= 1'b1; // Set wins over the permit
    end else if (sleep_allow_i) begin
      awake_ff <= 1'b0;
    end
  end

  sra_fifo #(
    .W     (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) sra_fifo_inst (
    .clk_i       (core_clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (commit_pend_ff),
    .in_ready_o  (fifo_ready),
    .in_data_i   (commit_ff),
    .out_valid_o (fifo_valid),
    .out_ready_i (wr_ready_i),
    .out_data_o  (fifo_out)
  );

  assign sdo_o        = sdo_ff;
  assign sdo_oe_n_o   = oe_n_ff;
  assign rd_req_o     = rd_req_ff;
  assign rd_addr_o    = rd_addr_ff;
  assign cur_addr_o   = addr_ff;
  assign wr_valid_o   = fifo_valid;
  assign wr_addr_o    = fifo_out[WORD_W-1 -: ADDR_W];
  assign wr_size_o    = fifo_out[DATA_W +: SIZE_W];
  assign wr_data_o    = fifo_out[DATA_W-1:0];
  assign wr_overrun_o = overrun_ff;
  assign stay_awake_o = awake_ff;
endmodule // sra_slave

`default_nettype wire

//--- sra_slave_bench.sv
// Self-checking bench for sra_slave with a serial master model.
// Assumes a pull-up on data-out and a one-cycle read source.
`timescale 1ns/1ns
`default_nettype none
module sra_slave_bench;
  import sra_pkg::*;
  logic        clk, nrst, init, wake, sleep, sclk, cs_n, mosi, sdo, oe_n, rd_req, wr_valid, wr_ready, ovr, stay;
  logic [13:0] rd_addr, cur_addr, wr_addr;
  logic [7:0]  rd_data, rx;
  logic [1:0]  reg_bytes, wr_size;
  logic [31:0] wr_data;
  logic [31:0] got[$];
  wire logic   miso;
  int          n_errors = 0;
  int          compares = 0;
  int          n_rq = 0;
  assign miso = oe_n ? 1'b1 : sdo;
  sra_host sra_host_inst (.core_clk_i(clk), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
  sra_slave sra_slave_inst (.core_clk_i(clk), .nrst_i(nrst), .init_done_i(init), .wake_busy_i(wake),
    .sleep_allow_i(sleep), .sclk_i(sclk), .cs_n_i(cs_n), .serial_data_in_i(mosi), .sdo_o(sdo), .sdo_oe_n_o(oe_n),
    .rd_req_o(rd_req), .rd_addr_o(rd_addr), .rd_data_i(rd_data), .cur_addr_o(cur_addr), .reg_bytes_i(reg_bytes),
    .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_addr_o(wr_addr), .wr_size_o(wr_size), .wr_data_o(wr_data),
    .wr_overrun_o(ovr), .stay_awake_o(stay));
  function automatic logic [7:0] pat(input logic [13:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction
  always @(negedge clk) begin
    if (rd_req) begin
      rd_data <= pat(rd_addr);
      n_rq++;
    end
    if (wr_valid && wr_ready)
      got.push_back({wr_addr, wr_size, wr_size == 2'h0 ? {8'h00, wr_data[7:0]} : wr_data[15:0]});
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic sx(input logic [7:0] t);
    sra_host_inst.xfer(t, rx);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [15:0] a);
    sra_host_inst.frame_on();
    sx(op);
    sx(a[15:8]);
    sx(a[7:0]);
    if (op == 8'h0B)
      sx(8'h3C); // Dummy content is ignored
  endtask
  task automatic t_uninit();
    cmd(8'h0B, 16'h0000);
    sx(8'hFF);
    sra_host_inst.frame_off();
    chk("uninit", {24'h0, rx}, {24'h0, 8'hFF});
    chk("uninit_rq", n_rq, 0);
  endtask
  task automatic t_init_mid();
    sra_host_inst.frame_on();
    sx(8'h02);
    init = 1'b1;
    sx(8'h00);
    sx(8'h40);
    sx(8'h77);
    sra_host_inst.frame_off();
    chk("midinit", got.size(), 0);
    chk("stay0", {31'h0, stay}, 0);
    cmd(8'h0B, 16'h0000); // Throwaway test register read
    sx(8'hFF);
    sra_host_inst.frame_off();
    chk("stay1", {31'h0, stay}, 1);
  endtask
  task automatic t_wake();
    wake = 1'b1;
    cmd(8'h0B, 16'h0005);
    wake = 1'b0;
    sx(8'hFF);
    sra_host_inst.frame_off();
    chk("wake", {24'h0, rx}, 0);
    cmd(8'h0B, 16'h0005); // Poll again in a separate frame
    sx(8'hFF);
    sra_host_inst.frame_off();
    chk("woke", {24'h0, rx}, {24'h0, pat(14'h0005)});
  endtask
  task automatic t_read(input logic [1:0] dir);
    logic [13:0] a;
    a = 14'h0101;
    cmd(8'h0B, {dir, a});
    for (int i = 0; i < 3; i++) begin
      sx(8'hFF);
      chk("rd", {24'h0, rx}, {24'h0, pat(a)});
      if (dir == 2'h2)
        a--;
      else if (dir != 2'h3)
        a++;
    end
    sra_host_inst.frame_off();
  endtask
  task automatic t_write();
    got.delete();
    reg_bytes = 2'h1;
    cmd(8'h02, 16'h0020);
    sx(8'h12);
    sx(8'h34);
    sx(8'h56); // Partial second register
    sra_host_inst.frame_off();
    reg_bytes = 2'h0;
    cmd(8'h02, 16'h8030);
    sx(8'hA1);
    sx(8'hB2);
    sra_host_inst.frame_off();
    chk("nwr", got.size(), 3);
    chk("w0", got[0], {14'h0020, 2'h1, 16'h3412});
    chk("w1", got[1], {14'h0030, 2'h0, 16'h00A1});
    chk("w2", got[2], {14'h002F, 2'h0, 16'h00B2});
    chk("wadr", {18'h0, cur_addr}, {18'h0, 14'h002E});
  endtask
  task automatic t_sleep();
    sleep = 1'b1;
    @(negedge clk);
    sleep = 1'b0;
    @(negedge clk);
    chk("sleep", {31'h0, stay}, 0);
  endtask
  // Stalled consumer: fill past depth, then drain to empty
  task automatic t_fill();
    got.delete();
    wr_ready = 1'b0;
    cmd(8'h02, 16'hC010);
    for (int i = 0; i < 40; i++)
      sx(8'(i));
    sra_host_inst.frame_off();
    chk("ovr", {31'h0, ovr}, 1);
    wr_ready = 1'b1;
    repeat (60) @(negedge clk);
    chk("drain", got.size(), 33);
    chk("f31", got[31], {14'h0010, 2'h0, 16'h001F});
    chk("empty", {31'h0, wr_valid}, 0);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    nrst = 1'b0;
    init = 1'b0;
    wake = 1'b0;
    sleep = 1'b0;
    rd_data = 8'h00;
    reg_bytes = 2'h0;
    wr_ready = 1'b1;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    t_uninit();
    t_init_mid();
    t_wake();
    for (int d = 0; d < 4; d++)
      t_read(2'(d));
    t_write();
    t_sleep();
    t_fill();
    tally_and_finish();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
endmodule // sra_slave_bench
`default_nettype wire

//--- sra_slave_chk.sv
// Port-level checker for sra_slave.
// Assumes one core clock domain; bound to every sra_slave instance.
`timescale 1ns/1ns
`default_nettype none
module sra_slave_chk (
  input wire logic                      core_clk_i,
  input wire logic                      nrst_i,
  input wire logic                      init_done_i,
  input wire logic                      wake_busy_i,
  input wire logic                      sleep_allow_i,
  input wire logic                      cs_n_i,
  input wire logic                      sdo_o,
  input wire logic                      sdo_oe_n_o,
  input wire logic                      rd_req_o,
  input wire logic                      wr_valid_o,
  input wire logic                      wr_ready_i,
  input wire logic [sra_pkg::ADDR_W-1:0] wr_addr_o,
  input wire logic [sra_pkg::DATA_W-1:0] wr_data_o,
  input wire logic                      stay_awake_o
);
  import sra_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  a_reset_quiet: assert property (disable iff (1'b0) !nrst_i |=> sdo_oe_n_o && !rd_req_o && !wr_valid_o)
    else $error("outputs active in reset");
  a_uninit_silent: assert property ((!init_done_i)[*4] |-> sdo_oe_n_o && !rd_req_o)
    else $error("activity before init");
  a_release_sdo: assert property (cs_n_i[*6] |-> sdo_oe_n_o)
    else $error("data-out driven with select high");
  a_drive_in_frame: assert property ($fell(sdo_oe_n_o) |-> !$past(cs_n_i, 3))
    else $error("drive began outside a frame");
  // Six cycles covers the select synchroniser
  a_wake_low: assert property ((init_done_i && wake_busy_i && !cs_n_i)[*6] |-> !sdo_oe_n_o && !sdo_o)
    else $error("data-out not low while waking");
  a_after_wake: assert property ((!cs_n_i && $fell(wake_busy_i)) ##1 !cs_n_i[*3] |-> !sdo_oe_n_o && !sdo_o)
    else $error("data-out not low after wake");
  a_rdreq_pulse: assert property (rd_req_o |=> !rd_req_o)
    else $error("fetch request longer than a cycle");
  a_sleep_only: assert property ($fell(stay_awake_o) |-> $past(sleep_allow_i))
    else $error("stay awake dropped without permission");
  a_sleep_clear: assert property (cs_n_i[*6] ##0 sleep_allow_i |=> !stay_awake_o)
    else $error("stay awake not cleared");
  a_wr_hold: assert property (wr_valid_o && !wr_ready_i |=>
    wr_valid_o && $stable(wr_addr_o) && $stable(wr_data_o))
    else $error("commit changed while stalled");
endmodule // sra_slave_chk
bind sra_slave sra_slave_chk sra_slave_chk_inst (.core_clk_i, .nrst_i, .init_done_i, .wake_busy_i, .sleep_allow_i,
  .cs_n_i, .sdo_o, .sdo_oe_n_o, .rd_req_o, .wr_valid_o, .wr_ready_i, .wr_addr_o, .wr_data_o, .stay_awake_o);
`default_nettype wire
